//--- rtl/tpmds_top.sv
// timer pin function select and pad drive strength registers on classic wishbone
`timescale 1ns/1ps
`include "tpmds_params.svh"
module tpmds_top (
   // clock and reset
   input  wire logic                     clk_i,
   input  wire logic                     rst_i,
   // wishbone slave
   input  wire logic                     cyc_i,
   input  wire logic                     stb_i,
   input  wire logic                     we_i,
   input  wire logic [7:0]               adr_i,
   input  wire logic [3:0]               sel_i,
   input  wire logic [31:0]              dat_i,
   output logic      [31:0]              dat_o,
   output logic                          ack_o,
   // reset configuration straps
   input  wire logic                     reset_config_pin_n_i,
   input  wire logic                     data_bus_bit21_i,
   // timer pin functions
   output tpmds_pkg::tpmds_func_type     tmr_in_func_o  [4],
   output tpmds_pkg::tpmds_func_type     tmr_out_func_o [4],
   // pad drive strengths, 1 is high drive
   output logic                          bus_main_pins_drive_o,
   output logic                          bus_control_pins_drive_o,
   output logic                          mgmt_pins_drive_o,
   output logic                          twowire_pins_drive_o
);
   import tpmds_pkg::*;

   // register storage
   logic [15:0] timer_pin_function_select;
   logic        bus_main_pins_drive;
   logic        bus_control_pins_drive;
   logic        mgmt_pins_drive;
   logic        twowire_pins_drive;

   // strap synchronisers and capture
   logic        cfg_meta;
   logic        cfg_sync;
   logic        d21_meta;
   logic        d21_sync;
   logic        strap_pend;
   logic        strap_val;

   // bus decode
   logic        req;
   logic        wr_commit;
   logic        hit_pinsel;
   logic        hit_busdrv;
   logic        hit_mgmtdrv;
   logic        wr_pinsel;
   logic        wr_busdrv;
   logic        wr_mgmtdrv;
   logic [31:0] rd_word;
   logic [15:0] next_pinsel;

   // word address match on a byte offset, low two bits ignored
   function automatic logic addr_hit(input logic [7:0] adr, input logic [7:0] ofs);
      addr_hit = (adr[7:2] == ofs[7:2]);
   endfunction

   // two flops on both straps; they run through reset so they are settled at release
   always_ff @(posedge clk_i) begin
      cfg_meta <= reset_config_pin_n_i;
      cfg_sync <= cfg_meta;
      d21_meta <= data_bus_bit21_i;
      d21_sync <= d21_meta;
   end

   // capture pending flag: the strap is loaded on the first edge after release
   always_ff @(posedge clk_i) begin
      strap_pend <= rst_i;
   end

   // config pin high forces low drive, low takes the sampled data bus bit
   assign strap_val = cfg_sync ? `TPMDS_DRV_RST : d21_sync;

   // request decode; a write lands only on the edge where ack is seen
   assign req         = cyc_i & stb_i;
   assign wr_commit   = req & we_i & ack_o;
   assign hit_pinsel  = addr_hit(adr_i, `TPMDS_OFS_PINSEL);
   assign hit_busdrv  = addr_hit(adr_i, `TPMDS_OFS_BUSDRV);
   assign hit_mgmtdrv = addr_hit(adr_i, `TPMDS_OFS_MGMTDRV);
   assign wr_pinsel   = wr_commit & hit_pinsel;
   assign wr_busdrv   = wr_commit & hit_busdrv & sel_i[0];
   assign wr_mgmtdrv  = wr_commit & hit_mgmtdrv & sel_i[0];

   // byte lane merge for the 16-bit select register
   assign next_pinsel = {sel_i[1] ? dat_i[15:8] : timer_pin_function_select[15:8],
                         sel_i[0] ? dat_i[7:0]  : timer_pin_function_select[7:0]};

   // read mux; reserved and unmapped bits read zero
   assign rd_word = hit_pinsel  ? {16'h0000, timer_pin_function_select} :
                    hit_busdrv  ? {27'h000_0000, bus_main_pins_drive, 3'h0, bus_control_pins_drive} :
                    hit_mgmtdrv ? {27'h000_0000, mgmt_pins_drive, 3'h0, twowire_pins_drive} :
                    32'h0000_0000;

   // ack one cycle after the request, dropped the cycle after; unmapped offsets ack too
   always_ff @(posedge clk_i) begin
      if (rst_i)
         ack_o <= 1'b0;
      else
         ack_o <= req & ~ack_o;
   end

   // read data sampled with the request so it stands while ack is high
   always_ff @(posedge clk_i) begin
      if (rst_i)
         dat_o <= 32'h0000_0000;
      else if (req & ~ack_o)
         dat_o <= rd_word;
   end

   // timer pin selectors, gpio after reset
   always_ff @(posedge clk_i) begin
      if (rst_i)
         timer_pin_function_select <= `TPMDS_PINSEL_RST;
      else if (wr_pinsel)
         timer_pin_function_select <= next_pinsel;
   end

   // bus drive bits; reserved bits are not stored, software keeps them zero
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         bus_main_pins_drive    <= `TPMDS_DRV_RST;
         bus_control_pins_drive <= `TPMDS_DRV_RST;
      end else if (strap_pend) begin
         bus_main_pins_drive    <= strap_val;
         bus_control_pins_drive <= strap_val;
      end else if (wr_busdrv) begin
         bus_main_pins_drive    <= dat_i[`TPMDS_DRV_HI_BIT];
         bus_control_pins_drive <= dat_i[`TPMDS_DRV_LO_BIT];
      end
   end

   // management and two-wire drive bits, same polarity as the bus bits
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         mgmt_pins_drive    <= `TPMDS_DRV_RST;
         twowire_pins_drive <= `TPMDS_DRV_RST;
      end else if (strap_pend) begin
         mgmt_pins_drive    <= strap_val;
         twowire_pins_drive <= strap_val;
      end else if (wr_mgmtdrv) begin
         mgmt_pins_drive    <= dat_i[`TPMDS_DRV_HI_BIT];
         twowire_pins_drive <= dat_i[`TPMDS_DRV_LO_BIT];
      end
   end

   // drive outputs are the stored bits themselves
   assign bus_main_pins_drive_o    = bus_main_pins_drive;
   assign bus_control_pins_drive_o = bus_control_pins_drive;
   assign mgmt_pins_drive_o        = mgmt_pins_drive;
   assign twowire_pins_drive_o     = twowire_pins_drive;

   // one decoder per pin and direction
   for (genvar g = 0; g < 4; g++) begin : g_pin
      tpmds_pin_decode #(
         .PIN       (g),
         .IS_OUTPUT (1'b0)
      ) u_in_dec (
         .clk_i  (clk_i),
         .rst_i  (rst_i),
         .code_i (timer_pin_function_select[`TPMDS_IN_SEL_LSB + 2*g +: 2]),
         .func_o (tmr_in_func_o[g])
      );
      tpmds_pin_decode #(
         .PIN       (g),
         .IS_OUTPUT (1'b1)
      ) u_out_dec (
         .clk_i  (clk_i),
         .rst_i  (rst_i),
         .code_i (timer_pin_function_select[`TPMDS_OUT_SEL_LSB + 2*g +: 2]),
         .func_o (tmr_out_func_o[g])
      );
   end

   // checks ------------------------------------------------------------
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   sequence s_wr_bus;
      wr_busdrv;
   endsequence

   sequence s_wr_mgmt;
      wr_mgmtdrv;
   endsequence

   sequence s_quiet;
      !wr_commit && !strap_pend;
   endsequence

   a_ack_one_cycle: assert property (req && !ack_o |=> ack_o ##1 !ack_o)
      else $error("ack not a single cycle after request");

   a_strap_load: assert property ($fell(rst_i) |=>
      bus_main_pins_drive_o == $past(strap_val) && twowire_pins_drive_o == $past(strap_val))
      else $error("drive bits did not take the reset strap");

   a_pinsel_reset: assert property ($fell(rst_i) |-> timer_pin_function_select == 16'h0000)
      else $error("timer selectors not gpio after reset");

   a_gpio_after_rst: assert property ($fell(rst_i) |=>
      tmr_in_func_o[3] == TPMDS_FN_GPIO && tmr_out_func_o[0] == TPMDS_FN_GPIO)
      else $error("timer pins not gpio after reset");

   a_bus_main_wr: assert property (s_wr_bus |=> bus_main_pins_drive_o == $past(dat_i[4]))
      else $error("bus main drive did not follow write");

   a_bus_ctrl_wr: assert property (s_wr_bus |=> bus_control_pins_drive_o == $past(dat_i[0]))
      else $error("bus control drive did not follow write");

   a_mgmt_drv_wr: assert property (s_wr_mgmt |=> mgmt_pins_drive_o == $past(dat_i[4]))
      else $error("mgmt drive did not follow write");

   a_twowire_drv_wr: assert property (s_wr_mgmt |=> twowire_pins_drive_o == $past(dat_i[0]))
      else $error("two-wire drive did not follow write");

   // the master must idle a cycle after ack, so the earliest read is taken two edges after the write
   a_drive_readback: assert property (s_wr_bus ##2 (req && !we_i && hit_busdrv && !ack_o)
      |=> dat_o[4] == $past(dat_i[4], 3) && dat_o[0] == $past(dat_i[0], 3))
      else $error("drive register read back differs");

   a_in_code_route: assert property (wr_pinsel && sel_i[1] && dat_i[15:14] == 2'h1
      |=> ##1 tmr_in_func_o[3] == TPMDS_FN_SPICS)
      else $error("input pin 3 not chip select 2 for code 01");

   a_out_code_route: assert property (wr_pinsel && sel_i[0] && dat_i[1:0] == 2'h2
      |=> ##1 tmr_out_func_o[0] == TPMDS_FN_DMA)
      else $error("output pin 0 not dma acknowledge for code 10");

   a_out_alt1_gpio: assert property (wr_pinsel && sel_i[0] && dat_i[3:2] == 2'h1
      |=> ##1 tmr_out_func_o[1] == TPMDS_FN_GPIO)
      else $error("output pin 1 not gpio for code 01");

   a_out_timer: assert property (wr_pinsel && sel_i[0] && dat_i[7:6] == 2'h3
      |=> ##1 tmr_out_func_o[3] == TPMDS_FN_TIMER)
      else $error("output pin 3 not timer output for code 11");

   a_static_outputs: assert property (s_quiet ##1 s_quiet |=>
      $stable(timer_pin_function_select) && $stable(bus_main_pins_drive_o) && $stable(twowire_pins_drive_o))
      else $error("selection changed without a write");

endmodule

//--- common/tpmds_params.svh
// offsets, field positions and reset values of the timer pin mux and drive block
`ifndef TPMDS_PARAMS_SVH
`define TPMDS_PARAMS_SVH

// register byte offsets on the wishbone port
`define TPMDS_OFS_PINSEL   8'h00
`define TPMDS_OFS_BUSDRV   8'h04
`define TPMDS_OFS_MGMTDRV  8'h08

// timer pin function select layout
`define TPMDS_IN_SEL_LSB   8
`define TPMDS_OUT_SEL_LSB  0
`define TPMDS_SEL_W        2
`define TPMDS_PINSEL_RST   16'h0000

// drive strength select layout
`define TPMDS_DRV_HI_BIT   4
`define TPMDS_DRV_LO_BIT   0
`define TPMDS_DRV_RST      1'h0

// selector codes
`define TPMDS_CODE_GPIO    2'h0
`define TPMDS_CODE_ALT1    2'h1
`define TPMDS_CODE_ALT2    2'h2
`define TPMDS_CODE_TIMER   2'h3

`endif

//--- common/tpmds_pkg.sv
// types shared by the timer pin mux and drive block
package tpmds_pkg;

   // one-hot function carried by a timer pin
   typedef enum logic [5:0] {
      TPMDS_FN_GPIO    = 6'h01,
      TPMDS_FN_TIMER   = 6'h02,
      TPMDS_FN_TMROUT  = 6'h04,
      TPMDS_FN_DMA     = 6'h08,
      TPMDS_FN_UART    = 6'h10,
      TPMDS_FN_SPICS   = 6'h20
   } tpmds_func_type;

endpackage

//--- rtl/tpmds_pin_decode.sv
// decode of one timer pin selector into the function that pin carries
`timescale 1ns/1ps
`include "tpmds_params.svh"
module tpmds_pin_decode #(
   parameter int unsigned PIN       = 0,
   parameter bit          IS_OUTPUT = 1'b0
) (
   // clock and reset
   input  wire logic                     clk_i,
   input  wire logic                     rst_i,
   // selector code from the function select register
   input  wire logic [1:0]               code_i,
   // registered function of the pin
   output tpmds_pkg::tpmds_func_type     func_o
);
   import tpmds_pkg::*;

   tpmds_func_type next_func;

   // table lookup: code 01 differs per pin and per direction, code 10 per pin only
   always_comb begin
      next_func = TPMDS_FN_GPIO;
      unique case (code_i)
         `TPMDS_CODE_GPIO: next_func = TPMDS_FN_GPIO;
         `TPMDS_CODE_ALT1: begin
            if (PIN == 3)
               next_func = TPMDS_FN_SPICS;
            else if (!IS_OUTPUT && PIN != 0)
               next_func = TPMDS_FN_TMROUT;
            else
               next_func = TPMDS_FN_GPIO;
         end
         `TPMDS_CODE_ALT2: next_func = (PIN == 3) ? TPMDS_FN_UART : TPMDS_FN_DMA;
         `TPMDS_CODE_TIMER: next_func = TPMDS_FN_TIMER;
      endcase
   end

   // held until the selector changes, so pads never see decode glitches
   always_ff @(posedge clk_i) begin
      if (rst_i)
         func_o <= TPMDS_FN_GPIO;
      else
         func_o <= next_func;
   end

   a_code_gpio_pin: assert property (@(posedge clk_i) disable iff (rst_i)
      code_i == `TPMDS_CODE_GPIO |=> func_o == TPMDS_FN_GPIO)
      else $error("gpio code did not give gpio function");

   a_code_timer_pin: assert property (@(posedge clk_i) disable iff (rst_i)
      code_i == `TPMDS_CODE_TIMER |=> func_o == TPMDS_FN_TIMER)
      else $error("timer code did not give timer function");

   a_code_alt2_pin: assert property (@(posedge clk_i) disable iff (rst_i)
      code_i == `TPMDS_CODE_ALT2 |=> (func_o == TPMDS_FN_UART) == (PIN == 3))
      else $error("code 10 gave wrong uart or dma function");

endmodule

//--- testbench/tpmds_pad_model.sv
// pad side model: reset straps and the data bus traffic behind bit 21
`timescale 1ns/1ps
module tpmds_pad_model (
   // clock and reset
   input  wire logic clk_i,
   input  wire logic rst_i,
   // strap levels chosen by the bench
   input  wire logic strap_cfg_i,
   input  wire logic strap_d21_i,
   // pads seen by the block
   output logic      reset_config_pin_n_o,
   output logic      data_bus_bit21_o
);
   logic bus_bit;

   // config pin is a board strap, changed by the bench only at each reset
   assign reset_config_pin_n_o = strap_cfg_i;

   // bus carries the strap only in reset, then traffic flips it every cycle
   always_ff @(posedge clk_i) begin
      bus_bit <= rst_i ? strap_d21_i : ~bus_bit;
   end
   assign data_bus_bit21_o = rst_i ? strap_d21_i : bus_bit;
endmodule

//--- testbench/tb.sv
// self-checking bench for the timer pin mux and drive block
`timescale 1ns/1ps
`include "tpmds_params.svh"
module tb;
   import tpmds_pkg::*;
   logic                  clk_i, rst_i, cyc_i, stb_i, we_i, ack_o, cfg, d21, cfg_pin, bus21;
   logic                  bm, bc, mg, tw;
   logic           [7:0]  adr_i, exp_bus, exp_mgmt;
   logic           [3:0]  sel_i;
   logic           [31:0] dat_i, dat_o, q, r;
   logic           [15:0] exp_pinsel;
   tpmds_func_type        fin [4];
   tpmds_func_type        fout [4];
   int                    n_mismatch, comparisons, seed, i;

   tpmds_top i_tpmds_top (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
      .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
      .reset_config_pin_n_i(cfg_pin), .data_bus_bit21_i(bus21), .tmr_in_func_o(fin),
      .tmr_out_func_o(fout), .bus_main_pins_drive_o(bm), .bus_control_pins_drive_o(bc),
      .mgmt_pins_drive_o(mg), .twowire_pins_drive_o(tw));
   tpmds_pad_model i_tpmds_pad_model (.clk_i(clk_i), .rst_i(rst_i), .strap_cfg_i(cfg),
      .strap_d21_i(d21), .reset_config_pin_n_o(cfg_pin), .data_bus_bit21_o(bus21));

   // clock at 50 MHz
   initial begin
      clk_i = 1'b0;
      forever #10 clk_i = ~clk_i;
   end

   task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
      comparisons++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("[FAIL] %0t %s seen %h expected %h", $time, msg, seen, exp);
      end
   endtask

   task automatic tally_and_finish;
      $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
      if (n_mismatch == 0 && comparisons > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask

   // expected function of one pin for one selector code
   function automatic tpmds_func_type fn_exp(input bit is_out, input int pin, input logic [1:0] code);
      case (code)
         2'h0: return TPMDS_FN_GPIO;
         2'h1: begin
            if (pin == 3) return TPMDS_FN_SPICS;
            return (!is_out && pin != 0) ? TPMDS_FN_TMROUT : TPMDS_FN_GPIO;
         end
         2'h2: return (pin == 3) ? TPMDS_FN_UART : TPMDS_FN_DMA;
         default: return TPMDS_FN_TIMER;
      endcase
   endfunction

   // one classic cycle; starts and ends just after a rising edge
   task automatic wb(input logic w, input logic [7:0] a, input logic [3:0] s, input logic [31:0] d);
      int n;
      n = 0;
      cyc_i <= 1'b1;
      stb_i <= 1'b1;
      we_i  <= w;
      adr_i <= a;
      sel_i <= s;
      dat_i <= d;
      @(posedge clk_i);
      while (ack_o !== 1'b1 && n < 50) begin
         @(posedge clk_i);
         n++;
      end
      if (n >= 50) check(32'h0, 32'h1, "no ack");
      q = dat_o;
      cyc_i <= 1'b0;
      stb_i <= 1'b0;
      we_i  <= 1'b0;
      @(posedge clk_i);
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] exp);
      wb(1'b0, a, 4'hf, 32'h0);
      check(q, exp, "read back");
   endtask

   // func outputs trail the write by a cycle, so let one edge land first
   task automatic check_all;
      @(posedge clk_i);
      #1;
      for (int p = 0; p < 4; p++) begin
         check(32'(fin[p]), 32'(fn_exp(0, p, exp_pinsel[8+2*p +: 2])), "in func");
         check(32'(fout[p]), 32'(fn_exp(1, p, exp_pinsel[2*p +: 2])), "out func");
      end
      check(32'(bm), 32'(exp_bus[4]), "bus main drive");
      check(32'(bc), 32'(exp_bus[0]), "bus control drive");
      check(32'(mg), 32'(exp_mgmt[4]), "mgmt drive");
      check(32'(tw), 32'(exp_mgmt[0]), "twowire drive");
      @(posedge clk_i);
   endtask

   task automatic do_reset(input logic c, input logic d);
      cfg   <= c;
      d21   <= d;
      rst_i <= 1'b1;
      repeat (3) @(posedge clk_i);
      rst_i <= 1'b0;
      exp_pinsel = 16'h0000;
      exp_bus    = c ? 8'h00 : {3'h0, d, 3'h0, d};
      exp_mgmt   = exp_bus;
      @(posedge clk_i);
      check_all();
      rd(`TPMDS_OFS_PINSEL, 32'h0000_0000);
      rd(`TPMDS_OFS_BUSDRV, {24'h0, exp_bus});
   endtask

   // watchdog, far beyond the few hundred cycles the tests need
   initial begin
      repeat (20000) @(posedge clk_i);
      n_mismatch++;
      tally_and_finish();
   end

   initial begin
      {cyc_i, stb_i, we_i, cfg, d21} = 5'h00;
      rst_i = 1'b1;
      adr_i = 8'h00;
      sel_i = 4'h0;
      dat_i = 32'h0000_0000;
      n_mismatch = 0;
      comparisons = 0;
      seed = 32'he2b9;
      @(posedge clk_i);
      for (i = 0; i < 4; i++) do_reset(i[1], i[0]);
      $display("test reset straps done");
      // every selector code on every pin, both lanes at once
      for (i = 0; i < 4; i++) begin
         exp_pinsel = {8{i[1:0]}};
         wb(1'b1, `TPMDS_OFS_PINSEL, 4'h3, {16'h0, exp_pinsel});
         check_all();
      end
      // random selectors through random byte lanes
      for (i = 0; i < 12; i++) begin
         r = $random(seed);
         wb(1'b1, `TPMDS_OFS_PINSEL, {2'b00, r[17:16]}, r);
         if (r[16]) exp_pinsel[7:0] = r[7:0];
         if (r[17]) exp_pinsel[15:8] = r[15:8];
         check_all();
         rd(`TPMDS_OFS_PINSEL, {16'h0, exp_pinsel});
      end
      $display("test pin select done");
      // drive registers: reserved bits written as zero, lane 0 only takes effect
      for (i = 0; i < 8; i++) begin
         r = $random(seed) & 32'h0000_0011;
         wb(1'b1, i[0] ? `TPMDS_OFS_MGMTDRV : `TPMDS_OFS_BUSDRV, 4'h1, r);
         if (i[0]) exp_mgmt = r[7:0];
         else exp_bus = r[7:0];
         rd(i[0] ? `TPMDS_OFS_MGMTDRV : `TPMDS_OFS_BUSDRV, r);
         wb(1'b1, i[0] ? `TPMDS_OFS_MGMTDRV : `TPMDS_OFS_BUSDRV, 4'he, ~r & 32'h11);
         check_all();
         rd(`TPMDS_OFS_BUSDRV, {24'h0, exp_bus});
         rd(`TPMDS_OFS_MGMTDRV, {24'h0, exp_mgmt});
      end
      $display("test drive strength done");
      // unmapped place is acked, reads zero and disturbs nothing
      wb(1'b1, 8'h0c, 4'hf, 32'hffff_ffff);
      rd(8'h0c, 32'h0000_0000);
      rd(`TPMDS_OFS_PINSEL, {16'h0, exp_pinsel});
      // outputs hold while the data bus strap toggles
      repeat (20) @(posedge clk_i);
      check_all();
      $display("test unmapped and static done");
      do_reset(1'b0, 1'b1);
      $display("test mid-run reset done");
      tally_and_finish();
   end
endmodule
